/* File: common/irmod_pkg.sv */
// Purpose : constants, types and register map of the infrared modulation combiner
// Assumes : apb slave with 32-bit data, one aligned word per register
// Notes   : mode codes 1010 to 1111 follow the same pattern as 1000 and 1001
package irmod_pkg;

  localparam logic [11:0] ctrl_offset    = 12'h074;
  localparam logic [11:0] route_offset   = 12'h078;
  localparam logic [11:0] status_offset  = 12'h07c;
  localparam int          mode_width     = 4;
  localparam logic [3:0]  mode_reset     = 4'h0;
  localparam int          mode_uart_bit  = 3;
  localparam int          mode_or_bit_t  = 2;
  localparam logic [1:0]  route_reset    = 2'h0;
  localparam logic [31:0] reg_reset      = 32'h0000_0000;

  // source vector indices
  localparam int src_t1c1 = 0;
  localparam int src_t1c2 = 1;
  localparam int src_t2c1 = 2;
  localparam int src_t2c2 = 3;
  localparam int src_tx1  = 4;
  localparam int src_tx2  = 5;
  localparam int src_count = 6;

  typedef struct packed {
    logic timer_one_channel_one;
    logic timer_one_channel_two;
    logic timer_two_channel_one;
    logic timer_two_channel_two;
    logic serial_one_transmit;
    logic serial_two_transmit;
  } sources_s;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef enum logic [1:0] {
    st_setup  = 2'b01,
    st_access = 2'b10
  } bus_state_e;

endpackage

/* File: sim/infrared_modulation_combiner_test.sv */
// Purpose : self-checking bench for the infrared modulation combiner
// Assumes : apb answers after one access cycle, sources settle in six cycles
// Notes   : each mode row holds two source patterns, bit 6 is the expected output
`timescale 1ns/1ps
module infrared_modulation_combiner_test
  import irmod_pkg::*;
;
  typedef struct packed {
    logic [3:0] mode;
    logic [6:0] v0;
    logic [6:0] v1;
  } row_s;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  sources_s    src     = '0;
  logic        pin_choice_a;
  logic        pin_choice_b;
  logic        pin_choice_a_oe;
  logic        pin_choice_b_oe;
  logic        emitter_lit;
  int          mismatches = 0;
  int          tests_run  = 0;
  row_s        rows [16] = '{
    '{4'h0,7'h68,7'h17}, '{4'h1,7'h64,7'h1b}, '{4'h2,7'h58,7'h27}, '{4'h3,7'h54,7'h2b},
    '{4'h4,7'h60,7'h17}, '{4'h5,7'h44,7'h1b}, '{4'h6,7'h50,7'h27}, '{4'h7,7'h44,7'h2b},
    '{4'h8,7'h62,7'h1d}, '{4'h9,7'h42,7'h1d}, '{4'ha,7'h52,7'h2d}, '{4'hb,7'h50,7'h2d},
    '{4'hc,7'h49,7'h36}, '{4'hd,7'h41,7'h36}, '{4'he,7'h45,7'h3a}, '{4'hf,7'h44,7'h3a}};

  // design and emitter
  infrared_modulation_combiner u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_one_channel_one(src.timer_one_channel_one), .timer_one_channel_two(src.timer_one_channel_two),
    .timer_two_channel_one(src.timer_two_channel_one), .timer_two_channel_two(src.timer_two_channel_two),
    .serial_one_transmit(src.serial_one_transmit), .serial_two_transmit(src.serial_two_transmit),
    .pin_choice_a(pin_choice_a), .pin_choice_b(pin_choice_b),
    .pin_choice_a_oe(pin_choice_a_oe), .pin_choice_b_oe(pin_choice_b_oe));
  ir_emitter_model u_emitter (
    .pin_choice_a(pin_choice_a), .pin_choice_a_oe(pin_choice_a_oe),
    .pin_choice_b(pin_choice_b), .pin_choice_b_oe(pin_choice_b_oe), .emitter_lit(emitter_lit));

  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // look at pready where it is settled, away from the edge that launches it
    @(negedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    // the rising edge that samples pready high completes the transfer
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apply(input logic [5:0] s);
    @(posedge pclk);
    src <= sources_s'(s);
    repeat (6) @(posedge pclk);
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    logic [6:0]  v;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ctrl_offset, 32'h0, q, e);
    chk(q, 32'h0);
    chk({pin_choice_a_oe, pin_choice_b_oe, emitter_lit}, 3'b000);
    apb(1'b1, route_offset, 32'h1, q, e);
    foreach (rows[i]) begin
      apb(1'b1, ctrl_offset, {28'h0, rows[i].mode}, q, e);
      apb(1'b0, ctrl_offset, 32'h0, q, e);
      chk(q, {28'h0, rows[i].mode});
      for (int k = 0; k < 2; k++) begin
        v = k ? rows[i].v1 : rows[i].v0;
        apply(v[5:0]);
        chk(pin_choice_a, v[6]);
        chk(emitter_lit, v[6]);
        apb(1'b0, status_offset, 32'h0, q, e);
        chk(q[0], v[6]);
      end
    end
    // route to the second pin, then to none
    apply(6'h04);
    apb(1'b1, route_offset, 32'h2, q, e);
    repeat (2) @(posedge pclk);
    chk({pin_choice_a_oe, pin_choice_a, pin_choice_b_oe, pin_choice_b}, 4'b0011);
    apb(1'b1, route_offset, 32'h0, q, e);
    repeat (2) @(posedge pclk);
    chk({pin_choice_a_oe, pin_choice_b_oe, emitter_lit}, 3'b000);
    // unmapped address is refused
    apb(1'b0, 12'h080, 32'h0, q, e);
    chk(e, 1'b1);
    chk(q, 32'h0);
    // reset in mid-run clears mode and route
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ctrl_offset, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, route_offset, 32'h0, q, e);
    chk(q, 32'h0);
    tally_and_finish();
  end
endmodule

/* File: sim/ir_emitter_model.sv */
// Purpose : infrared emitter seen from the two candidate output pins
// Assumes : an undriven pin is pulled low, so the emitter stays dark
// Notes   : lit level is high while any driven pin is high
`timescale 1ns/1ps
module ir_emitter_model (
  // pin side
  input  wire logic pin_choice_a,
  input  wire logic pin_choice_a_oe,
  input  wire logic pin_choice_b,
  input  wire logic pin_choice_b_oe,
  // observed light
  output logic      emitter_lit
);
  // wire level from each pin's enable, pull-down when released
  assign emitter_lit = (pin_choice_a_oe & pin_choice_a) | (pin_choice_b_oe & pin_choice_b);
endmodule

/* File: verilog/infrared_modulation_combiner.sv */
// Purpose : combine carrier and data sources into the infrared output, apb control
// Assumes : sources arrive from other blocks and are synchronised here
// Notes   : transmit only; pin function and port lock live in the port logic
`timescale 1ns/1ps
module infrared_modulation_combiner
  import irmod_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // carrier and data sources
  input  wire logic        timer_one_channel_one,
  input  wire logic        timer_one_channel_two,
  input  wire logic        timer_two_channel_one,
  input  wire logic        timer_two_channel_two,
  input  wire logic        serial_one_transmit,
  input  wire logic        serial_two_transmit,
  // output pins
  output logic             pin_choice_a,
  output logic             pin_choice_b,
  output logic             pin_choice_a_oe,
  output logic             pin_choice_b_oe
);

  typedef struct packed {
    logic [mode_width-1:0] modulation_select;
    logic [1:0]            route;      // bit0 pin a, bit1 pin b
    logic [31:0]           rdata;
    logic                  ready;
    logic                  slverr;
    logic                  modulated_infrared_output;
    logic                  pa;
    logic                  pb;
    logic                  pa_oe;
    logic                  pb_oe;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;

  logic [src_count-1:0] src_sync;
  logic                 carrier;
  logic                 data_sig;
  logic                 combined;
  logic                 setup_phase;
  logic                 access_phase;

  // synchronise the internal source lines; serial transmit used without a pin
  irmod_sync #(.width(src_count)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({serial_two_transmit, serial_one_transmit, timer_two_channel_two,
                timer_two_channel_one, timer_one_channel_two, timer_one_channel_one}),
    .sync_out (src_sync)
  );

  // source pairing from the mode field
  always_comb begin
    carrier  = 1'b0;
    data_sig = 1'b0;
    if (state_reg.modulation_select[mode_uart_bit]) begin
      data_sig = state_reg.modulation_select[2] ? src_sync[src_tx2] : src_sync[src_tx1];
      case (state_reg.modulation_select[2:1])
        2'h0:    carrier = src_sync[src_t1c1];
        2'h1:    carrier = src_sync[src_t1c2];
        2'h2:    carrier = src_sync[src_t2c1];
        default: carrier = src_sync[src_t2c2];
      endcase
    end else begin
      carrier  = state_reg.modulation_select[1] ? src_sync[src_t1c2] : src_sync[src_t1c1];
      data_sig = state_reg.modulation_select[0] ? src_sync[src_t2c2] : src_sync[src_t2c1];
    end
  end

  // operation: timer modes use bit 2, serial modes use bit 0
  always_comb begin
    logic use_or;
    use_or = state_reg.modulation_select[mode_uart_bit] ? state_reg.modulation_select[0]
                                                        : state_reg.modulation_select[mode_or_bit_t];
    combined = use_or ? (carrier | data_sig) : (carrier & data_sig);
  end

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;

  // register file, bus answer and output staging
  always_comb begin
    state_next        = state_reg;
    state_next.ready  = 1'b0;
    state_next.slverr = 1'b0;
    if (setup_phase) begin
      state_next.ready = 1'b1;
      state_next.rdata = reg_reset;
      case (paddr)
        ctrl_offset:   state_next.rdata[mode_width-1:0] = state_reg.modulation_select;
        route_offset:  state_next.rdata[1:0] = state_reg.route;
        status_offset: state_next.rdata[0] = state_reg.modulated_infrared_output;
        default:       state_next.slverr = 1'b1;
      endcase
    end
    if (access_phase && state_reg.ready && pwrite) begin
      case (paddr)
        ctrl_offset:  state_next.modulation_select = pwdata[mode_width-1:0];
        route_offset: state_next.route = pwdata[1:0];
        default:      state_next.route = state_reg.route;
      endcase
    end
    if (access_phase && state_reg.ready) begin
      state_next.rdata = reg_reset;
    end
    state_next.modulated_infrared_output = combined;
    state_next.pa     = combined & state_reg.route[0];
    state_next.pb     = combined & state_reg.route[1];
    state_next.pa_oe  = state_reg.route[0];
    state_next.pb_oe  = state_reg.route[1];
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg                   <= '0;
      state_reg.modulation_select <= mode_reset;
      state_reg.route             <= route_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata          = state_reg.rdata;
  assign pready          = state_reg.ready;
  assign pslverr         = state_reg.slverr;
  assign pin_choice_a    = state_reg.pa;
  assign pin_choice_b    = state_reg.pb;
  assign pin_choice_a_oe = state_reg.pa_oe;
  assign pin_choice_b_oe = state_reg.pb_oe;

  // assertions
  a_reset_mode_zero: assert property (@(posedge pclk) $rose(presetn) |-> state_reg.modulation_select == mode_reset)
    else $error("mode not zero after reset");
  a_mode_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && pready && pwrite && paddr == ctrl_offset |=> state_reg.modulation_select == $past(pwdata[3:0]))
    else $error("mode write lost");
  a_mode_readback: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && paddr == ctrl_offset |=> pready && prdata == {28'h0, state_reg.modulation_select})
    else $error("mode readback wrong");
  a_and_default: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.modulation_select == 4'h0 |=> state_reg.modulated_infrared_output == $past(src_sync[0] & src_sync[2]))
    else $error("and of first channels wrong");
  a_or_timer: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.modulation_select == 4'h7 |=> state_reg.modulated_infrared_output == $past(src_sync[1] | src_sync[3]))
    else $error("or of second channels wrong");
  a_uart_and: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.modulation_select == 4'h8 |=> state_reg.modulated_infrared_output == $past(src_sync[4] & src_sync[0]))
    else $error("serial and wrong");
  a_uart_or: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.modulation_select == 4'h9 |=> state_reg.modulated_infrared_output == $past(src_sync[4] | src_sync[0]))
    else $error("serial or wrong");
  a_route_pin_b: assert property (@(posedge pclk) disable iff (!presetn)
    !state_reg.route[1] |=> !pin_choice_b && !pin_choice_b_oe)
    else $error("pin b driven while unrouted");
  a_answer_one: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  c_mode_write: cover property (@(posedge pclk) access_phase && pready && pwrite && paddr == ctrl_offset);
  c_uart_mode:  cover property (@(posedge pclk) state_reg.modulation_select[3] && state_reg.modulated_infrared_output);
  c_pin_a_high: cover property (@(posedge pclk) pin_choice_a && pin_choice_a_oe);

endmodule

/* File: verilog/irmod_sync.sv */
// Purpose : three-stage synchroniser with second/third agreement for source pins
// Assumes : one clock pclk, asynchronous active-low reset
// Notes   : first stage feeds only the second stage
`timescale 1ns/1ps
module irmod_sync #(
  parameter int width = 6
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // data
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);

  typedef struct packed {
    logic [width-1:0] s1;
    logic [width-1:0] s2;
    logic [width-1:0] s3;
    logic [width-1:0] held;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // shift chain and per-bit agreement filter
  always_comb begin
    state_next    = state_reg;
    state_next.s1 = async_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < width; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.held[i] = state_reg.s3[i];
      end
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.held;

endmodule
